// >>> hdl/iec_top.sv
// Operation
// - an acknowledge sets in-service bits, so a coincident read under enabled interrupts shows the old value.
// - trap return with exception-pending 1 and nmi-pending 0 restores from the exception save pair.
// - trap return with exception-pending 0 and nmi-pending 1 restores from the nmi save pair.
// - trap return with both flags 0 restores from the maskable save pair.
// - debug save registers are reachable from an illegal opcode until the debug return.
// - debug save registers are reachable from the debug trap until the debug return.
// - moving a pin from interrupt to port use gates off its edge selects, so it raises no spurious request.
// - after reset the nmi pin is in interrupt use but detects no edge until an edge is selected.
`timescale 1ns/100ps
`default_nettype none
module iec_top
  import iec_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu core side
  input wire logic ack_valid,
  input wire logic [2:0] ack_level,
  input wire logic return_from_trap,
  input wire logic illegal_opcode_exec,
  input wire logic debug_trap_instr,
  input wire logic debug_return_instr,
  input wire logic [31:0] debug_pc_in,
  input wire logic [31:0] debug_psw_in,
  output logic [1:0] restore_sel,
  output logic restore_valid,
  output logic debug_window_open,
  // pins: nmi is bit 0, ext_irq_pins_0_3 bits 1..4, port3 bit-1 is bit 5
  input wire logic [ALL_PINS-1:0] irq_pins,
  output logic [ALL_PINS-1:0] irq_request
);
  logic [15:0] mask_reg_third;
  logic [7:0] in_service_priority;
  logic [1:0] sys_flags;
  logic [9:0] port0_edge;
  logic [1:0] port3_edge;
  logic [5:0] port_mode;
  logic [5:0] pend;
  logic [31:0] debug_saved_pc;
  logic [31:0] debug_saved_status;
  logic interrupts_enabled_state;
  iec_dbg_t dbg_state;
  logic ack_done;
  logic [ALL_PINS-1:0] fall_sel;
  logic [ALL_PINS-1:0] rise_sel;
  logic [ALL_PINS-1:0] hit;

  // byte-lane merge of a write onto an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction : lane_merge

  // one wait cycle on reads so readdata is registered
  logic rd_done;
  assign avs_waitrequest = avs_read & ~rd_done;
  wire wr_go = avs_write;
  wire rd_go = avs_read & ~rd_done;
  wire sel_mask = avs_address == OFS_MASK_THIRD;
  wire sel_isp = avs_address == OFS_IN_SERVICE;
  wire sel_flags = avs_address == OFS_SYS_FLAGS;
  wire sel_p0 = avs_address == OFS_P0_EDGE;
  wire sel_p3 = avs_address == OFS_P3_EDGE;
  wire sel_mode = avs_address == OFS_PORT_MODE;
  wire sel_pend = avs_address == OFS_PEND;
  wire sel_dpc = avs_address == OFS_DBG_PC;
  wire sel_dpsw = avs_address == OFS_DBG_PSW;
  wire sel_ei = avs_address == OFS_EI;
  wire dbg_ok = dbg_state == iec_dbg_open;
  // merge onto the register being written, never onto stale read data
  wire [31:0] merged_pc = lane_merge(debug_saved_pc, avs_writedata, avs_byteenable);
  wire [31:0] merged_psw = lane_merge(debug_saved_status, avs_writedata, avs_byteenable);
  wire [31:0] wmask = lane_merge(32'h0000_0000, 32'hffff_ffff, avs_byteenable);

  // read mux; debug save pair reads zero outside its window
  wire [31:0] rd_mux =
    sel_mask ? {16'h0000, mask_reg_third} :
    sel_isp ? {24'h000000, in_service_priority} :
    sel_flags ? {30'h00000000, sys_flags} :
    sel_p0 ? {22'h000000, port0_edge} :
    sel_p3 ? {30'h00000000, port3_edge} :
    sel_mode ? {26'h0000000, port_mode} :
    sel_pend ? {26'h0000000, pend} :
    (sel_dpc & dbg_ok) ? debug_saved_pc :
    (sel_dpsw & dbg_ok) ? debug_saved_status :
    sel_ei ? {31'h00000000, interrupts_enabled_state} :
    32'h0000_0000;

  // read data register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_readdata <= 32'h0000_0000;
      rd_done <= 1'b0;
    end
    else
    begin
      rd_done <= rd_go;
      if (rd_go)
        avs_readdata <= rd_mux;
    end
  end

  // in-service: an acknowledge sets its level bit in the same edge a read samples
  wire [7:0] isp_set = (ack_valid & interrupts_enabled_state) ? (8'h01 << ack_level) : 8'h00;
  assign ack_done = ack_valid & interrupts_enabled_state;
  wire [7:0] isp_wr = avs_writedata[7:0] & wmask[7:0];
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      in_service_priority <= ISP_RST;
    else if (wr_go & sel_isp)
      in_service_priority <= (in_service_priority & ~isp_wr) | isp_set; // write one clears, set wins
    else
      in_service_priority <= in_service_priority | isp_set;
  end

  // global enable, mask and flags; fixed mask bits read back as written, reset one
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      interrupts_enabled_state <= 1'b0;
      mask_reg_third <= MASK_THIRD_RST;
      sys_flags <= FLAGS_RST;
    end
    else if (wr_go)
    begin
      if (sel_ei & avs_byteenable[0])
        interrupts_enabled_state <= avs_writedata[0];
      if (sel_mask)
        mask_reg_third <= (mask_reg_third & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
      if (sel_flags & avs_byteenable[0])
        sys_flags <= avs_writedata[1:0];
    end
  end

  // edge selects and port mode registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      port0_edge <= P0_EDGE_RST;
      port3_edge <= P3_EDGE_RST;
      port_mode <= PORT_MODE_RST;
    end
    else if (wr_go)
    begin
      if (sel_p0)
        port0_edge <= (port0_edge & ~wmask[9:0]) | (avs_writedata[9:0] & wmask[9:0]);
      if (sel_p3 & avs_byteenable[0])
        port3_edge <= avs_writedata[1:0];
      if (sel_mode & avs_byteenable[0])
        port_mode <= avs_writedata[5:0];
    end
  end

  // trap return restore source from the flags
  wire [1:0] next_sel =
    (sys_flags[FLAG_EP] & ~sys_flags[FLAG_NP]) ? iec_src_exception :
    (~sys_flags[FLAG_EP] & sys_flags[FLAG_NP]) ? iec_src_nmi : iec_src_maskable;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      restore_sel <= iec_src_maskable;
      restore_valid <= 1'b0;
    end
    else
    begin
      restore_valid <= return_from_trap;
      if (return_from_trap)
        restore_sel <= next_sel;
    end
  end

  // debug window: opens on illegal opcode or debug trap, closes on debug return
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dbg_state <= iec_dbg_closed;
      debug_saved_pc <= 32'h0000_0000;
      debug_saved_status <= 32'h0000_0000;
    end
    else
    begin
      case (dbg_state)
        iec_dbg_closed:
          if (illegal_opcode_exec | debug_trap_instr)
          begin
            dbg_state <= iec_dbg_open;
            debug_saved_pc <= debug_pc_in;
            debug_saved_status <= debug_psw_in;
          end
        iec_dbg_open:
          if (debug_return_instr)
            dbg_state <= iec_dbg_closed;
          else if (wr_go & sel_dpc)
            debug_saved_pc <= merged_pc; // writes outside the window are dropped
          else if (wr_go & sel_dpsw)
            debug_saved_status <= merged_psw;
        default:
          dbg_state <= iec_dbg_closed;
      endcase
    end
  end
  assign debug_window_open = dbg_ok;

  // edge selects per pin; nmi starts at 00 so it detects nothing
  genvar g;
  generate
    for (g = 0; g < P0_PINS; g++)
    begin : g_p0
      assign fall_sel[g] = port0_edge[2*g];
      assign rise_sel[g] = port0_edge[2*g+1];
    end
  endgenerate
  assign fall_sel[ALL_PINS-1] = port3_edge[0];
  assign rise_sel[ALL_PINS-1] = port3_edge[1];

  // port mode gates both edge selects of each detector, so a mode change
  // with edges still armed raises no spurious request
  generate
    for (g = 0; g < ALL_PINS; g++)
    begin : g_det
      iec_edge_det u_det (
        .clk(clk),
        .resetn(resetn),
        .pin(irq_pins[g]),
        .fall_sel(fall_sel[g] & ~port_mode[g]),
        .rise_sel(rise_sel[g] & ~port_mode[g]),
        .hit(hit[g])
      );
    end
  endgenerate

  // sticky pending; a hit wins over a write-one clear
  wire [5:0] pend_clr = (wr_go & sel_pend) ? (avs_writedata[5:0] & wmask[5:0]) : 6'h00;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pend <= 6'h00;
    else
      pend <= (pend & ~pend_clr) | hit;
  end
  assign irq_request = pend;

endmodule : iec_top
`default_nettype wire

// >>> hdl/iec_pkg.sv
package iec_pkg;
  // register byte offsets on the avalon slave
  localparam logic [5:0] OFS_MASK_THIRD = 6'h00;
  localparam logic [5:0] OFS_IN_SERVICE = 6'h04;
  localparam logic [5:0] OFS_SYS_FLAGS = 6'h08;
  localparam logic [5:0] OFS_P0_EDGE = 6'h0c;
  localparam logic [5:0] OFS_P3_EDGE = 6'h10;
  localparam logic [5:0] OFS_PORT_MODE = 6'h14;
  localparam logic [5:0] OFS_PEND = 6'h18;
  localparam logic [5:0] OFS_DBG_PC = 6'h1c;
  localparam logic [5:0] OFS_DBG_PSW = 6'h20;
  localparam logic [5:0] OFS_EI = 6'h24;
  // reset values
  localparam logic [15:0] MASK_THIRD_RST = 16'hffff;
  localparam logic [15:0] MASK_THIRD_FIXED = 16'hf8f0;
  localparam logic [7:0] ISP_RST = 8'h00;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [9:0] P0_EDGE_RST = 10'h000;
  localparam logic [1:0] P3_EDGE_RST = 2'h0;
  localparam logic [5:0] PORT_MODE_RST = 6'h00;
  // system flag field positions
  localparam int FLAG_EP = 1;
  localparam int FLAG_NP = 0;
  // pin counts
  localparam int P0_PINS = 5;
  localparam int ALL_PINS = 6;
  // restore source select for the trap return
  typedef enum logic [1:0] {
    iec_src_maskable = 2'b00,
    iec_src_nmi = 2'b01,
    iec_src_exception = 2'b11
  } iec_src_t;
  // debug window state, gray along open/close
  typedef enum logic [1:0] {
    iec_dbg_closed = 2'b00,
    iec_dbg_open = 2'b01
  } iec_dbg_t;
endpackage : iec_pkg

// >>> hdl/iec_edge_det.sv
`timescale 1ns/100ps
`default_nettype none
module iec_edge_det
  import iec_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  input wire logic fall_sel,
  input wire logic rise_sel,
  output logic hit
);
  logic sync1;
  logic sync2;
  logic last;
  // two flops for the asynchronous pin
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      last <= sync2;
    end
  end
  // 00 disables, each bit arms its own edge
  assign hit = (fall_sel & last & ~sync2) | (rise_sel & ~last & sync2);
endmodule : iec_edge_det
`default_nettype wire

// >>> testbench/iec_checker.sv
`timescale 1ns/100ps
`default_nettype none
module iec_checker
  import iec_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic return_from_trap,
  input wire logic illegal_opcode_exec,
  input wire logic debug_trap_instr,
  input wire logic debug_return_instr,
  input wire logic [1:0] restore_sel,
  input wire logic restore_valid,
  input wire logic debug_window_open,
  input wire logic [ALL_PINS-1:0] irq_request
);
  logic [1:0] flags;
  logic nmi_armed;
  // shadow of written flags, and a sticky bit set once the nmi edge select is written nonzero; writes never wait
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags <= FLAGS_RST;
      nmi_armed <= 1'b0;
    end
    else if (avs_write)
    begin
      if (avs_address == OFS_SYS_FLAGS) flags <= avs_writedata[1:0];
      if (avs_address == OFS_P0_EDGE && avs_writedata[1:0] != 2'h0) nmi_armed <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_trap_ret(logic [1:0] f);
    return_from_trap && flags == f;
  endsequence
  a_restore_pulse: assert property (return_from_trap |=> restore_valid)
    else $error("restore pulse missing");
  a_restore_exc: assert property (s_trap_ret(2'b10) |=> restore_sel == 2'b11)
    else $error("exception restore wrong");
  a_restore_nmi: assert property (s_trap_ret(2'b01) |=> restore_sel == 2'b01)
    else $error("nmi restore wrong");
  a_restore_mask: assert property (s_trap_ret(2'b00) |=> restore_sel == 2'b00)
    else $error("maskable restore wrong");
  a_dbg_open_ill: assert property (illegal_opcode_exec |=> debug_window_open)
    else $error("window not opened by illegal opcode");
  a_dbg_open_trap: assert property (debug_trap_instr |=> debug_window_open)
    else $error("window not opened by debug trap");
  a_dbg_close: assert property (debug_return_instr && !illegal_opcode_exec && !debug_trap_instr
    |=> !debug_window_open) else $error("window not closed");
  a_nmi_quiet: assert property ($rose(irq_request[0]) |-> nmi_armed)
    else $error("nmi request without edge select");
endmodule : iec_checker
bind iec_top iec_checker u_chk (.clk(clk), .resetn(resetn), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .return_from_trap(return_from_trap),
  .illegal_opcode_exec(illegal_opcode_exec), .debug_trap_instr(debug_trap_instr),
  .debug_return_instr(debug_return_instr), .restore_sel(restore_sel), .restore_valid(restore_valid),
  .debug_window_open(debug_window_open), .irq_request(irq_request));
`default_nettype wire

// >>> testbench/iec_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module iec_pin_model
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] level,
  output logic [5:0] pins
);
  // pins move just after an edge, unrelated to any select setting
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) pins <= 6'h00;
    else pins <= level;
  end
endmodule : iec_pin_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import iec_pkg::*;
;
  logic clk, resetn, rd_en, wr_en, wreq, rvalid, wopen;
  logic [5:0] addr, pin_lvl, pins, req;
  logic [31:0] wdata, rdata, pcin, pswin;
  logic [4:0] ev;
  logic [2:0] lvl;
  logic [1:0] rsel;
  // flag pairs as {exception_pending, nmi_pending} and the save pair each selects
  logic [1:0] fl [3] = '{2'b10, 2'b01, 2'b00};
  logic [1:0] sel_exp [3] = '{2'b11, 2'b01, 2'b00};
  int fail_count, cmp_count;
  iec_top u_iec_top (.clk(clk), .resetn(resetn), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .ack_valid(ev[0]), .ack_level(lvl), .return_from_trap(ev[1]), .illegal_opcode_exec(ev[2]),
    .debug_trap_instr(ev[3]), .debug_return_instr(ev[4]), .debug_pc_in(pcin), .debug_psw_in(pswin),
    .restore_sel(rsel), .restore_valid(rvalid), .debug_window_open(wopen), .irq_pins(pins), .irq_request(req));
  iec_pin_model u_iec_pin_model (.clk(clk), .resetn(resetn), .level(pin_lvl), .pins(pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  // one bus cycle; held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd_en <= !w;
    wr_en <= w;
    do @(negedge clk); while (wreq !== 1'b0);
    @(posedge clk);
    if (!w) chk(rdata, exp);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
    @(negedge clk);
  endtask : pulse
  task automatic setp(input logic [5:0] v);
    @(posedge clk);
    pin_lvl <= v;
    repeat (8) @(posedge clk);
  endtask : setp
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial
  begin
    {resetn, rd_en, wr_en, addr, wdata, ev, lvl, pcin, pswin, pin_lvl} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    bus(0, OFS_MASK_THIRD, 0, {16'h0, MASK_THIRD_RST});
    bus(1, OFS_MASK_THIRD, 32'h0000f8f3, 0);
    bus(0, OFS_MASK_THIRD, 0, 32'h0000f8f3);
    bus(0, 6'h3c, 0, 0);
    lvl <= 3'h3;
    pulse(0);
    bus(0, OFS_IN_SERVICE, 0, 0);
    bus(1, OFS_EI, 1, 0);
    pulse(0);
    bus(0, OFS_IN_SERVICE, 0, 32'h08);
    bus(1, OFS_IN_SERVICE, 32'hff, 0);
    bus(0, OFS_IN_SERVICE, 0, 0);
    // flag pairs 10, 01 and 00 each pick their save pair
    for (int i = 0; i < 3; i++)
    begin
      bus(1, OFS_SYS_FLAGS, {30'h0, fl[i]}, 0);
      pulse(1);
      chk({29'h0, rvalid, rsel}, {29'h0, 1'b1, sel_exp[i]});
    end
    // debug window by both openers
    pcin <= 32'h1234abcd;
    pswin <= 32'h000000a5;
    bus(0, OFS_DBG_PC, 0, 0);
    pulse(2);
    chk({31'h0, wopen}, 1);
    bus(0, OFS_DBG_PC, 0, 32'h1234abcd);
    pulse(4);
    bus(0, OFS_DBG_PC, 0, 0);
    pulse(3);
    bus(0, OFS_DBG_PSW, 0, 32'h000000a5);
    pulse(4);
    bus(0, OFS_DBG_PSW, 0, 0);
    // edges: none before select, then only the chosen one
    setp(6'h3f);
    setp(6'h00);
    bus(0, OFS_PEND, 0, 0);
    bus(1, OFS_P0_EDGE, 32'h1, 0);
    setp(6'h01);
    bus(0, OFS_PEND, 0, 0);
    setp(6'h00);
    bus(0, OFS_PEND, 0, 32'h01);
    bus(1, OFS_P0_EDGE, 0, 0);
    bus(1, OFS_PEND, 32'h3f, 0);
    bus(1, OFS_P3_EDGE, 32'h2, 0);
    setp(6'h20);
    chk({26'h0, req}, 32'h20);
    bus(1, OFS_P3_EDGE, 0, 0);
    bus(1, OFS_PEND, 32'h3f, 0);
    bus(1, OFS_PORT_MODE, 32'h3f, 0);
    setp(6'h00);
    chk({26'h0, req}, 0);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
